// ===== src/dsc_scan.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Scan rows top down, left to right for chars-per-row bytes.
// RULE2: Graphics line start is last start plus pitch.
// RULE3: Text bitmap rows reread one line's bytes, row index advancing.
// RULE4: After the last bitmap row the line start gains the pitch.
// RULE5: Graphics byte holds 8, 4 or 2 pixels; text byte one code.
// RULE6: 1 bpp graphics takes eight times a text screen's memory.
// RULE7: Dual panel reads upper then lower line, one line each.
// RULE8: Line ends with total-chars minus chars idle read slots; the code always gives at least one.
// RULE9: Host touches text memory only during line idle.
// RULE10: Graphics mode takes host memory accesses at any time.
// RULE11: Dual panel idles after each half; line pulse after lower.
// RULE12: One cursor register is cursor position and access address.
// RULE13: Each memory access steps the cursor in the set direction.
// RULE14: Host saves and restores cursor around off-screen accesses.
// RULE15: Cursor in first layer if select bit 0, else third layer.
// RULE16: Cursor hidden outside its layer's memory region.
// RULE17: With no text screen only a bar cursor is drawn.
// RULE18: Mixed first layer, block shape: block over text, bar else.
// RULE19: Each block starts at its own scroll start register.
// RULE20: Host blanks the exposed bottom line after a scroll.
// RULE21: Host adds pitch to scroll down, subtracts to scroll up.
// RULE22: Pixel offset shifts text; zero in 2 and 4 bpp.
module dsc_scan #(
    parameter int RD_DIVIDE = dsc_pkg::RD_DIV
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [7:0] mem_rdata_in,
    output dsc_pkg::dsc_fetch_s fetch_out,
    output dsc_pkg::dsc_host_s host_out,
    output dsc_pkg::dsc_cursor_s cursor_out,
    output logic [3:0] char_row_out,
    output logic line_pulse_out,
    output logic frame_pulse_out,
    output logic scan_idle_out,
    output logic [2:0] pixel_hscroll_offset_out,
    output logic [3:0] pix_per_byte_out
);
    import dsc_pkg::*;

    // Register file storage
    logic [7:0] regs_reg [0:R_LAST];
    logic [7:0] regs_next [0:R_LAST];
    logic [15:0] csr_reg, csr_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    dsc_host_s host_reg, host_next;

    // Scan state
    dsc_scan_e st_reg, st_next;
    logic [7:0] div_reg, div_next;
    logic [7:0] col_reg, col_next;
    logic [7:0] idle_reg, idle_next;
    logic [3:0] row_reg, row_next;
    logic [7:0] line_reg, line_next;
    logic [15:0] up_reg, up_next;
    logic [15:0] lo_reg, lo_next;
    logic lower_reg, lower_next;
    dsc_fetch_s fetch_reg, fetch_next;
    logic lp_reg, lp_next;
    logic fp_reg, fp_next;
    dsc_cursor_s cur_reg, cur_next;
    logic [2:0] hs_reg, hs_next;
    logic [3:0] ppb_reg, ppb_next;

    logic rd_en, bus_req, wr_acc, rd_acc, gfx, dual;
    logic [5:0] idx;
    logic [15:0] pitch, sad1, sad2, sad3, span;

    // Word pair from two byte registers
    function automatic logic [15:0] pair(input logic [7:0] lo,
                                         input logic [7:0] hi);
        pair = {hi, lo};
    endfunction : pair

    // Cursor step after a memory access
    function automatic logic [15:0] step(input logic [15:0] a,
                                         input logic [1:0] dir,
                                         input logic [15:0] ap);
        case (dir)
            DIR_RIGHT: step = a + 16'h0001;
            DIR_LEFT: step = a - 16'h0001;
            DIR_UP: step = a - ap;
            default: step = a + ap;
        endcase
    endfunction : step

    // Pixels carried by one graphics byte
    function automatic logic [3:0] ppb(input logic [1:0] bpp);
        if (bpp == BPP_1) begin
            ppb = 4'h8;
        end else if (bpp == BPP_2) begin
            ppb = 4'h4;
        end else begin
            ppb = 4'h2;
        end
    endfunction : ppb

    // Register-file indices that answer; others read 0 unless cursor, data or status
    function automatic logic mapped(input logic [5:0] i);
        if (i == R_MODE || i == R_FY || i == R_CR || i == R_TCR) begin
            mapped = 1'b1;
        end else if (i == R_APL || i == R_APH) begin
            mapped = 1'b1;
        end else if (i >= R_SAD1L && i <= R_SAD3H) begin
            mapped = 1'b1;
        end else if (i >= R_CSHAPE && i <= R_OVL) begin
            mapped = 1'b1;
        end else if (i == R_HDOT) begin
            mapped = 1'b1;
        end else if (i >= R_SCAN && i <= R_SPANH) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    endfunction : mapped

    // Decoded views of the register file
    assign idx = wb_adr_in[7:2];
    assign bus_req = wb_cyc_in && wb_stb_in && !ack_reg;
    assign pitch = pair(regs_reg[R_APL], regs_reg[R_APH]);
    assign sad1 = pair(regs_reg[R_SAD1L], regs_reg[R_SAD1H]);
    assign sad2 = pair(regs_reg[R_SAD2L], regs_reg[R_SAD2H]);
    assign sad3 = pair(regs_reg[R_SAD3L], regs_reg[R_SAD3H]);
    assign span = pair(regs_reg[R_SPANL], regs_reg[R_SPANH]);
    assign gfx = regs_reg[R_SCAN][B_GFX];
    assign dual = regs_reg[R_MODE][B_DUAL];
    assign rd_en = (div_reg == 8'(RD_DIVIDE - 1));
    // Data port taken in any mode, no scan stall
    assign wr_acc = bus_req && wb_we_in && wb_sel_in[0] && idx == R_DATA; // RULE10
    assign rd_acc = bus_req && !wb_we_in && idx == R_DATA; // RULE10

    // Bus slave: ack one cycle after the request
    always_comb begin
        ack_next = bus_req;
        rdat_next = rdat_reg;
        host_next = '0;
        for (int i = 0; i <= R_LAST; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (bus_req && wb_we_in && wb_sel_in[0] && mapped(idx)) begin
            regs_next[idx] = wb_dat_in[7:0];
        end
        if (bus_req && !wb_we_in) begin
            if (idx == R_CSRL) begin
                rdat_next = 32'(csr_reg[7:0]);
            end else if (idx == R_CSRH) begin
                rdat_next = 32'(csr_reg[15:8]);
            end else if (idx == R_DATA) begin
                rdat_next = 32'(mem_rdata_in);
            end else if (idx == R_STAT) begin
                rdat_next = {24'h000000, row_reg, 1'b0, lower_reg,
                             cur_reg.visible, st_reg == ST_IDLE};
            end else if (mapped(idx)) begin
                rdat_next = 32'(regs_reg[idx]);
            end else begin
                rdat_next = '0;
            end
        end
        // Host access at the cursor address
        if (wr_acc || rd_acc) begin
            host_next.addr = csr_reg; // RULE12
            host_next.data = wb_dat_in[7:0];
            host_next.wr = wr_acc;
            host_next.rd = rd_acc;
        end
    end

    // Cursor: bus write loads, access steps
    always_comb begin
        csr_next = csr_reg;
        if (bus_req && wb_we_in && wb_sel_in[0] && idx == R_CSRL) begin
            csr_next = {csr_reg[15:8], wb_dat_in[7:0]}; // RULE12
        end else if (bus_req && wb_we_in && wb_sel_in[0] &&
                     idx == R_CSRH) begin
            csr_next = {wb_dat_in[7:0], csr_reg[7:0]}; // RULE12
        end else if (wr_acc || rd_acc) begin
            csr_next = step(csr_reg, regs_reg[R_CDIR][1:0], pitch); // RULE13
        end
    end

    // Read cycle divider; one fetch slot per pulse
    always_comb begin
        if (rd_en) begin
            div_next = 8'h00;
        end else begin
            div_next = div_reg + 8'h01;
        end
    end

    // Raster walk over display memory
    always_comb begin
        st_next = st_reg;
        col_next = col_reg;
        idle_next = idle_reg;
        row_next = row_reg;
        line_next = line_reg;
        up_next = up_reg;
        lo_next = lo_reg;
        lower_next = lower_reg;
        fetch_next = '0;
        fetch_next.addr = fetch_reg.addr;
        fetch_next.lower = fetch_reg.lower;
        lp_next = 1'b0;
        fp_next = 1'b0;
        if (rd_en) begin
            case (st_reg)
                ST_ACTIVE: begin
                    // Text byte is one character code
                    fetch_next.addr = (lower_reg ? lo_reg : up_reg) +
                                      {8'h00, col_reg}; // RULE1 RULE5
                    fetch_next.rd = 1'b1;
                    fetch_next.lower = lower_reg;
                    if (col_reg + 8'h01 >= regs_reg[R_CR]) begin
                        col_next = 8'h00; // RULE1
                        st_next = ST_IDLE;
                        // Pause still counts read slots, drive stays on
                        if (regs_reg[R_TCR] > regs_reg[R_CR]) begin
                            idle_next = regs_reg[R_TCR] -
                                        regs_reg[R_CR]; // RULE8
                        end else begin
                            idle_next = 8'h00;
                        end
                    end else begin
                        col_next = col_reg + 8'h01;
                    end
                end
                ST_IDLE: begin
                    if (idle_reg > 8'h01) begin
                        idle_next = idle_reg - 8'h01; // RULE8
                    end else if (dual && !lower_reg) begin
                        // Upper half done; now lower half
                        lower_next = 1'b1; // RULE7 RULE11
                        st_next = ST_ACTIVE;
                    end else begin
                        lower_next = 1'b0;
                        st_next = ST_ACTIVE;
                        lp_next = 1'b1; // RULE11
                        if (!gfx && row_reg < regs_reg[R_FY][3:0]) begin
                            // Same character bytes, next bitmap row
                            row_next = row_reg + 4'h1; // RULE3
                        end else begin
                            // Text steps per character line,
                            // graphics per pixel line: 8x memory
                            row_next = 4'h0; // RULE4
                            up_next = up_reg + pitch; // RULE2 RULE4 RULE6
                            lo_next = lo_reg + pitch; // RULE2 RULE7
                        end
                        if (line_reg >= regs_reg[R_LPF]) begin
                            line_next = 8'h00;
                            row_next = 4'h0;
                            up_next = sad1; // RULE19
                            lo_next = sad2; // RULE19
                            fp_next = 1'b1;
                        end else begin
                            line_next = line_reg + 8'h01; // RULE1
                        end
                    end
                end
                default: begin
                    st_next = ST_ACTIVE;
                end
            endcase
        end
    end

    // Cursor layer, shape, visibility and pixel offset
    always_comb begin
        logic [15:0] base;
        logic [15:0] off;
        logic l1_text;
        base = 16'h0000;
        off = 16'h0000;
        l1_text = 1'b0;
        cur_next = '0;
        cur_next.addr = csr_reg;
        cur_next.third_layer = regs_reg[R_OVL][B_OV]; // RULE15
        base = regs_reg[R_OVL][B_OV] ? sad3 : sad1; // RULE15
        off = csr_reg - base;
        // Hidden outside its layer
        cur_next.visible = csr_reg >= base && off < span; // RULE16
        l1_text = !regs_reg[R_OVL][B_DM1] && !gfx;
        if (!regs_reg[R_SCAN][B_TXT]) begin
            cur_next.block = 1'b0; // RULE17
        end else begin
            // Block over text, bar over graphics
            cur_next.block = regs_reg[R_CSHAPE][B_CM] && l1_text; // RULE18
        end
        // Fractional shift only makes sense at 1 bpp
        if (regs_reg[R_BPP][1:0] == BPP_1) begin
            hs_next = regs_reg[R_HDOT][2:0]; // RULE22
        end else begin
            hs_next = 3'h0; // RULE22
        end
        ppb_next = ppb(regs_reg[R_BPP][1:0]); // RULE5
    end

    // Register stage for all groups
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i <= R_LAST; i++) begin
                regs_reg[i] <= RST_BYTE;
            end
            regs_reg[R_FY] <= RST_FY;
            regs_reg[R_CR] <= RST_CR;
            regs_reg[R_TCR] <= RST_TCR;
            regs_reg[R_APL] <= RST_APL;
            regs_reg[R_LPF] <= RST_LPF;
            regs_reg[R_CDIR] <= RST_CDIR;
            csr_reg <= 16'h0000;
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            host_reg <= '0;
            st_reg <= ST_ACTIVE;
            div_reg <= 8'h00;
            col_reg <= 8'h00;
            idle_reg <= 8'h00;
            row_reg <= 4'h0;
            line_reg <= 8'h00;
            up_reg <= 16'h0000;
            lo_reg <= 16'h0000;
            lower_reg <= 1'b0;
            fetch_reg <= '0;
            lp_reg <= 1'b0;
            fp_reg <= 1'b0;
            cur_reg <= '0;
            hs_reg <= 3'h0;
            ppb_reg <= 4'h8;
        end else begin
            for (int i = 0; i <= R_LAST; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            csr_reg <= csr_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            host_reg <= host_next;
            st_reg <= st_next;
            div_reg <= div_next;
            col_reg <= col_next;
            idle_reg <= idle_next;
            row_reg <= row_next;
            line_reg <= line_next;
            up_reg <= up_next;
            lo_reg <= lo_next;
            lower_reg <= lower_next;
            fetch_reg <= fetch_next;
            lp_reg <= lp_next;
            fp_reg <= fp_next;
            cur_reg <= cur_next;
            hs_reg <= hs_next;
            ppb_reg <= ppb_next;
        end
    end

    // Outputs straight from flops
    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;
    assign fetch_out = fetch_reg;
    assign host_out = host_reg;
    assign cursor_out = cur_reg;
    assign char_row_out = row_reg;
    assign line_pulse_out = lp_reg;
    assign frame_pulse_out = fp_reg;
    // Safe host window in text mode
    assign scan_idle_out = (st_reg == ST_IDLE); // RULE9
    assign pixel_hscroll_offset_out = hs_reg;
    assign pix_per_byte_out = ppb_reg;
endmodule : dsc_scan
`default_nettype wire

// ===== pkg/dsc_pkg.sv
`default_nettype none
package dsc_pkg;
    // Register indices; byte address is 4x index
    localparam logic [5:0] R_MODE = 6'h00;
    localparam logic [5:0] R_FY = 6'h02;
    localparam logic [5:0] R_CR = 6'h03;
    localparam logic [5:0] R_TCR = 6'h04;
    localparam logic [5:0] R_APL = 6'h06;
    localparam logic [5:0] R_APH = 6'h07;
    localparam logic [5:0] R_SAD1L = 6'h0B;
    localparam logic [5:0] R_SAD1H = 6'h0C;
    localparam logic [5:0] R_SAD2L = 6'h0E;
    localparam logic [5:0] R_SAD2H = 6'h0F;
    localparam logic [5:0] R_SAD3L = 6'h11;
    localparam logic [5:0] R_SAD3H = 6'h12;
    localparam logic [5:0] R_CSHAPE = 6'h16;
    localparam logic [5:0] R_CDIR = 6'h17;
    localparam logic [5:0] R_OVL = 6'h18;
    localparam logic [5:0] R_HDOT = 6'h1B;
    localparam logic [5:0] R_CSRL = 6'h1C;
    localparam logic [5:0] R_CSRH = 6'h1D;
    localparam logic [5:0] R_SCAN = 6'h20;
    localparam logic [5:0] R_BPP = 6'h21;
    localparam logic [5:0] R_LPF = 6'h22;
    localparam logic [5:0] R_SPANL = 6'h23;
    localparam logic [5:0] R_SPANH = 6'h24;
    localparam logic [5:0] R_DATA = 6'h25;
    localparam logic [5:0] R_STAT = 6'h26;
    localparam logic [5:0] R_LAST = 6'h26;
    // Field positions
    localparam int B_DUAL = 3;
    localparam int B_CM = 7;
    localparam int B_OV = 4;
    localparam int B_DM1 = 2;
    localparam int B_GFX = 0;
    localparam int B_TXT = 1;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_FY = 8'h07;
    localparam logic [7:0] RST_CR = 8'h27;
    localparam logic [7:0] RST_TCR = 8'h2F;
    localparam logic [7:0] RST_APL = 8'h28;
    localparam logic [7:0] RST_LPF = 8'hEF;
    localparam logic [7:0] RST_CDIR = 8'h00;
    // Cursor step directions
    localparam logic [1:0] DIR_RIGHT = 2'h0;
    localparam logic [1:0] DIR_LEFT = 2'h1;
    localparam logic [1:0] DIR_UP = 2'h2;
    localparam logic [1:0] DIR_DOWN = 2'h3;
    // Bits per pixel codes
    localparam logic [1:0] BPP_1 = 2'h0;
    localparam logic [1:0] BPP_2 = 2'h1;
    // Memory read cycle, in input clocks
    localparam int RD_DIV = 4;

    typedef enum logic [0:0] {ST_ACTIVE, ST_IDLE} dsc_scan_e;

    // One display memory fetch
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic lower;
    } dsc_fetch_s;

    // Host memory access at the cursor
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } dsc_host_s;

    // Cursor as seen by the pixel pipeline
    typedef struct packed {
        logic [15:0] addr;
        logic visible;
        logic block;
        logic third_layer;
    } dsc_cursor_s;
endpackage : dsc_pkg
`default_nettype wire

// ===== tb/dsc_scan_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_scan_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire dsc_pkg::dsc_fetch_s fetch_out,
    input wire dsc_pkg::dsc_host_s host_out,
    input wire dsc_pkg::dsc_cursor_s cursor_out,
    input wire logic line_pulse_out,
    input wire logic frame_pulse_out,
    input wire logic scan_idle_out,
    input wire logic [2:0] pixel_hscroll_offset_out,
    input wire logic [3:0] pix_per_byte_out
);
    import dsc_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic run_reg;
    logic [15:0] last_reg;
    // Last fetch address; a pause ends a run
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_reg <= 1'b0;
            last_reg <= 16'h0000;
        end else begin
            if (scan_idle_out) run_reg <= 1'b0;
            else if (fetch_out.rd) run_reg <= 1'b1;
            if (fetch_out.rd) last_reg <= fetch_out.addr;
        end
    end
    // Ack one cycle after the taking edge
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out) else $error("ack missing");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    a_host_ack: assert property (host_out.wr || host_out.rd |-> wb_ack_out)
        else $error("memory access outside bus cycle");
    a_idle_nofetch: assert property (scan_idle_out && $past(scan_idle_out)
        |-> !fetch_out.rd) else $error("fetch in pause");
    a_fetch_step: assert property (fetch_out.rd && run_reg
        |-> fetch_out.addr == last_reg + 16'h0001)
        else $error("fetch address not consecutive");
    a_frame_line: assert property (frame_pulse_out |-> line_pulse_out)
        else $error("frame pulse off line end");
    a_pix_code: assert property (pix_per_byte_out == 4'h8
        || pix_per_byte_out == 4'h4 || pix_per_byte_out == 4'h2)
        else $error("bad pixels per byte");
    a_hscroll_zero: assert property (pixel_hscroll_offset_out != 3'h0
        |-> pix_per_byte_out == 4'h8) else $error("offset in gray");
    c_line: cover property (line_pulse_out);
    c_frame: cover property (frame_pulse_out);
    c_host: cover property (host_out.wr);
    c_block: cover property (cursor_out.visible && cursor_out.block);
endmodule : dsc_scan_checker
bind dsc_scan dsc_scan_checker dsc_scan_checker_i (
    .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .fetch_out(fetch_out),
    .host_out(host_out), .cursor_out(cursor_out),
    .line_pulse_out(line_pulse_out), .frame_pulse_out(frame_pulse_out),
    .scan_idle_out(scan_idle_out),
    .pixel_hscroll_offset_out(pixel_hscroll_offset_out),
    .pix_per_byte_out(pix_per_byte_out));
`default_nettype wire

// ===== tb/dsc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_panel_model (
    input wire logic clk_in,
    input wire dsc_pkg::dsc_fetch_s fetch_in,
    input wire dsc_pkg::dsc_cursor_s cursor_in,
    input wire logic [3:0] char_row_in,
    input wire logic line_pulse_in,
    input wire logic frame_pulse_in,
    input wire logic scan_idle_in,
    output logic [7:0] mem_rdata_out
);
    import dsc_pkg::*;
    logic [15:0] start [8];
    logic [3:0] row [8];
    logic low [8];
    int cnt [8];
    int idl [8];
    int lps [8];
    logic [2:0] k = 3'h0;
    logic run = 1'b0;
    logic restart = 1'b1;
    // Byte from the cursor address
    assign mem_rdata_out = cursor_in.addr[7:0] ^ 8'hA5;
    // One record per fetch run; restart at frame
    always @(posedge clk_in) begin
        if (frame_pulse_in) restart = 1'b1;
        if (line_pulse_in) lps[k] = lps[k] + 1;
        if (fetch_in.rd && !run) begin
            k = restart ? 3'h0 : k + 3'h1;
            restart = 1'b0;
            start[k] = fetch_in.addr;
            low[k] = fetch_in.lower;
            row[k] = char_row_in;
            cnt[k] = 0;
            idl[k] = 0;
            lps[k] = 0;
            run = 1'b1;
        end
        if (fetch_in.rd) cnt[k] = cnt[k] + 1;
        if (scan_idle_in) begin
            run = 1'b0;
            idl[k] = idl[k] + 1;
        end
    end
endmodule : dsc_panel_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsc_pkg::*;
    logic clk_in, rst_in, wb_cyc, wb_stb, wb_we, wb_ack, lp, fp, idle;
    logic [7:0] wb_adr, mem_rdata, rv;
    logic [31:0] wb_dat, wb_rd;
    logic [3:0] char_row, ppb;
    logic [2:0] hs;
    logic [15:0] csr;
    dsc_fetch_s fetch;
    dsc_host_s host, hcap;
    dsc_cursor_s cur;
    int bad_count, compares;
    localparam logic [5:0] RIDX [7] = '{R_FY, R_CR, R_TCR, R_APL, R_LPF,
        R_CDIR, 6'h3F};
    localparam logic [7:0] REXP [7] = '{8'h07, 8'h27, 8'h2F, 8'h28, 8'hEF,
        8'h00, 8'h00};
    dsc_scan #(.RD_DIVIDE(1)) dsc_scan_i (.clk_in(clk_in), .rst_in(rst_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(4'h1), .wb_dat_in(wb_dat),
        .wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .mem_rdata_in(mem_rdata),
        .fetch_out(fetch), .host_out(host), .cursor_out(cur),
        .char_row_out(char_row), .line_pulse_out(lp), .frame_pulse_out(fp),
        .scan_idle_out(idle), .pixel_hscroll_offset_out(hs),
        .pix_per_byte_out(ppb));
    dsc_panel_model dsc_panel_model_i (.clk_in(clk_in), .fetch_in(fetch),
        .cursor_in(cur), .char_row_in(char_row), .line_pulse_in(lp),
        .frame_pulse_in(fp), .scan_idle_in(idle), .mem_rdata_out(mem_rdata));
    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Classic cycle held until ack
    task automatic bus(input logic [5:0] idx, input logic w,
        input logic [7:0] d);
        int n;
        @(posedge clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h000000, d};
        for (n = 0; n < 40 && wb_ack !== 1'b1; n++) @(posedge clk_in);
        if (wb_ack !== 1'b1) bad_count++;
        rv = wb_rd[7:0];
        hcap = host;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask : wr
    task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        chk("register", 16'(exp), 16'(rv));
    endtask : rchk
    task automatic set_csr(input logic [15:0] v);
        wr(R_CSRL, v[7:0]);
        wr(R_CSRH, v[15:8]);
    endtask : set_csr
    // Wait n pulses; a missing one is a mismatch
    task automatic wait_ev(input logic frame, input int n);
        int t;
        repeat (n) begin
            @(posedge clk_in);
            for (t = 0; t < 400 && (frame ? fp : lp) !== 1'b1; t++)
                @(posedge clk_in);
            if ((frame ? fp : lp) !== 1'b1) bad_count++;
        end
    endtask : wait_ev
    task automatic cur_case(input logic [7:0] ovl, input logic [7:0] scan,
        input logic [15:0] pos, input logic [2:0] exp);
        wr(R_OVL, ovl);
        wr(R_SCAN, scan);
        set_csr(pos);
        repeat (2) @(posedge clk_in);
        chk("cursor", 16'(exp), 16'({cur.visible, cur.block, cur.third_layer}));
    endtask : cur_case
    // Fetch run: start, 4 bytes, 3 pause slots, half
    task automatic seg(input int k, input logic [15:0] st, input logic lw);
        chk("run start", st, dsc_panel_model_i.start[k]);
        chk("run count", 16'h0004, 16'(dsc_panel_model_i.cnt[k]));
        chk("run pause", 16'h0003, 16'(dsc_panel_model_i.idl[k]));
        chk("run half", 16'(lw), 16'(dsc_panel_model_i.low[k]));
    endtask : seg
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst_in, wb_cyc, wb_stb, wb_we} = 4'h8;
        wb_adr = 8'h00;
        wb_dat = 32'h00000000;
        bad_count = 0;
        compares = 0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        wr(6'h3F, 8'h55);
        for (int i = 0; i < 7; i++) rchk(RIDX[i], REXP[i]);
        // Short frame
        wr(R_LPF, 8'h03);
        wr(R_CR, 8'h04);
        wr(R_TCR, 8'h07);
        wr(R_APL, 8'h10);
        set_csr(16'h0100);
        csr = 16'h0100;
        for (int d = 0; d < 4; d++) begin
            wr(R_CDIR, 8'(d));
            wr(R_DATA, 8'h30 + 8'(d));
            chk("wr addr", csr, hcap.wr ? hcap.addr : 16'hFFFF);
            chk("wr data", 16'h0030 + 16'(d), 16'(hcap.data));
            csr = d == 0 ? csr + 16'h1 : d == 1 ? csr - 16'h1 :
                d == 2 ? csr - 16'h10 : csr + 16'h10;
            rchk(R_CSRL, csr[7:0]);
            rchk(R_CSRH, csr[15:8]);
        end
        bus(R_DATA, 1'b0, 8'h00);
        chk("rd data", 16'(csr[7:0] ^ 8'hA5), 16'(rv));
        chk("rd addr", csr, hcap.rd ? hcap.addr : 16'hFFFF);
        rchk(R_CSRL, csr[7:0] + 8'h10);
        wr(R_HDOT, 8'h05);
        for (int b = 0; b < 3; b++) begin
            wr(R_BPP, 8'(b));
            repeat (2) @(posedge clk_in);
            chk("per byte", 16'(b == 0 ? 8 : b == 1 ? 4 : 2), 16'(ppb));
            chk("offset", b == 0 ? 16'h5 : 16'h0, 16'(hs));
        end
        wr(R_BPP, 8'h00);
        wr(R_SAD1H, 8'h02);
        wr(R_SAD2H, 8'h04);
        wr(R_SAD3H, 8'h08);
        wr(R_SPANH, 8'h01);
        wr(R_CSHAPE, 8'h80);
        cur_case(8'h00, 8'h02, 16'h0210, 3'b110);
        cur_case(8'h10, 8'h02, 16'h0210, 3'b011);
        cur_case(8'h10, 8'h02, 16'h08FF, 3'b111);
        cur_case(8'h10, 8'h02, 16'h0900, 3'b011);
        cur_case(8'h00, 8'h01, 16'h0210, 3'b100);
        cur_case(8'h04, 8'h02, 16'h0210, 3'b100);
        cur_case(8'h00, 8'h03, 16'h0210, 3'b100);
        // Graphics lines one pitch apart
        wr(R_SCAN, 8'h01);
        wait_ev(1'b1, 2);
        wait_ev(1'b0, 3);
        seg(0, 16'h0200, 1'b0);
        seg(1, 16'h0210, 1'b0);
        // Text, two rows, scrolled one line
        wr(R_SAD1L, 8'h10);
        wr(R_DATA, 8'h20);
        wr(R_FY, 8'h01);
        wr(R_SCAN, 8'h02);
        wait_ev(1'b1, 2);
        wait_ev(1'b0, 4);
        seg(0, 16'h0210, 1'b0);
        seg(1, 16'h0210, 1'b0);
        seg(2, 16'h0220, 1'b0);
        chk("row", 16'h1, 16'(dsc_panel_model_i.row[1]));
        // Dual panel, pulse after lower half
        wr(R_SAD1L, 8'h00);
        wr(R_MODE, 8'h08);
        wr(R_SCAN, 8'h01);
        wait_ev(1'b1, 2);
        wait_ev(1'b0, 2);
        seg(0, 16'h0200, 1'b0);
        seg(1, 16'h0400, 1'b1);
        seg(2, 16'h0210, 1'b0);
        chk("upper pulse", 16'h0, 16'(dsc_panel_model_i.lps[0]));
        chk("lower pulse", 16'h1, 16'(dsc_panel_model_i.lps[1]));
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
